/* File: design/abm_pkg.sv */
// constants for the backplane bus master controller
package abm_pkg;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int IO_OFS_W = 13;
  localparam logic [21:0] IO_PAGE_WORDS = 22'h001000;
  localparam int CLK_MHZ = 20;
  localparam int SETUP_NS = 150;
  localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int TIMEOUT_US = 10;
  localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
  localparam int CNT_W = 12;
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_IACK = 2'h2;
  typedef enum logic [3:0] {
    ABM_IDLE = 4'h0,
    ABM_ADDR = 4'h1,
    ABM_SYNC = 4'h2,
    ABM_STRB = 4'h3,
    ABM_WAIT = 4'h4,
    ABM_DONE = 4'h5,
    ABM_REL = 4'h6,
    ABM_IAK = 4'h7,
    ABM_IAKW = 4'h8
  } abm_state_type;
endpackage : abm_pkg

/* File: design/abm_sync.sv */
// two flip-flop synchroniser for asynchronous bus inputs
`timescale 1ns/100ps
`default_nettype none
module abm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      meta_r <= '0;
      sync_out <= '0;
    end else if (ce_in) begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : abm_sync
`default_nettype wire

/* File: design/abm_master.sv */
// bus master controller driving an asynchronous interlocked backplane
// How it works
// - this controller is the only initiator
// - every strobe waits for slave reply interlock or the timeout
// - top 4 Kwords form the I/O page
// - io page select raised for I/O page addresses
// - interrupts acknowledged only between user operations
// - returned vector handed to user as pointer
// - same-level priority by electrical nearness; the controller drives int_ack_out with no grant chain
// - position priority follows bus position; levels five and six are simply ORed into irq_pending_out
// - extended lines carry address, then memory error
// - level five and six request lines separate
// - narrow units only in restricted systems
// - address strobe held until transaction ends
`timescale 1ns/100ps
`default_nettype none
module abm_master #(
  parameter int TIMEOUT = abm_pkg::TIMEOUT_CYC
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire logic req_valid_in,
  input wire logic [1:0] req_op_in,
  input wire logic [21:0] req_addr_in,
  input wire logic [15:0] req_wdata_in,
  output logic req_ready_out,
  output logic rsp_valid_out,
  output logic [15:0] rsp_rdata_out,
  output logic rsp_timeout_out,
  output logic rsp_mem_err_out,
  input wire logic [21:0] addr_data_lines_in,
  output logic [21:0] addr_data_lines_out,
  output logic addr_data_lines_oe_out,
  output logic addr_phase_strobe_out,
  output logic read_data_strobe_out,
  output logic write_data_strobe_out,
  output logic write_byte_out,
  output logic io_page_select_out,
  output logic int_ack_out,
  input wire logic slave_reply_in,
  input wire logic irq_level_five_in,
  input wire logic irq_level_six_in,
  output logic irq_pending_out
);
  abm_pkg::abm_state_type state_r;
  abm_pkg::abm_state_type state_nxt;
  logic [abm_pkg::CNT_W-1:0] cnt_r;
  logic [1:0] op_r;
  logic [21:0] addr_r;
  logic [15:0] wdata_r;
  logic reply_s;
  logic irq5_s;
  logic irq6_s;
  logic [21:0] dal_s;
  abm_sync #(.WIDTH(3)) u_ctl_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .ce_in(ce_in),
    .async_in({slave_reply_in, irq_level_five_in, irq_level_six_in}),
    .sync_out({reply_s, irq5_s, irq6_s})
  );
  // data settles well before reply is seen after two stages
  abm_sync #(.WIDTH(22)) u_dal_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .ce_in(ce_in),
    .async_in(addr_data_lines_in),
    .sync_out(dal_s)
  );

  // io page is the top 4 Kwords of the 22-bit address space
  function automatic logic in_io_page(input logic [21:0] a);
    in_io_page = (a >= (22'h3FFFFF - abm_pkg::IO_PAGE_WORDS * 22'h000002 + 22'h000001));
  endfunction : in_io_page

  // in the io page only the offset bits are meaningful to slaves
  function automatic logic [21:0] drive_addr(input logic [21:0] a);
    drive_addr = in_io_page(a) ? {9'h1FF, a[abm_pkg::IO_OFS_W-1:0]} : a;
  endfunction : drive_addr

  wire take_req = req_valid_in && (state_r == abm_pkg::ABM_IDLE);
  wire irq_any = irq5_s || irq6_s;
  wire cnt_zero = (cnt_r == '0);
  wire timed_out = (cnt_r == TIMEOUT[abm_pkg::CNT_W-1:0]);
  wire is_write = (op_r == abm_pkg::OP_WRITE);
  wire is_io = in_io_page(addr_r);
  // slaves get the whole address and decode their own registers
  wire [21:0] addr_drv = drive_addr(addr_r);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      abm_pkg::ABM_IDLE: begin
        if (take_req) begin
          if (req_op_in == abm_pkg::OP_IACK) begin
            state_nxt = abm_pkg::ABM_IAK;
          end else begin
            state_nxt = abm_pkg::ABM_ADDR;
          end
        end
      end
      abm_pkg::ABM_ADDR: begin
        if (cnt_zero) begin
          state_nxt = abm_pkg::ABM_SYNC;
        end
      end
      abm_pkg::ABM_SYNC: begin
        if (cnt_zero) begin
          state_nxt = abm_pkg::ABM_STRB;
        end
      end
      abm_pkg::ABM_STRB: begin
        if (cnt_zero) begin
          state_nxt = abm_pkg::ABM_WAIT;
        end
      end
      abm_pkg::ABM_WAIT: begin
        if (reply_s || timed_out) begin
          state_nxt = abm_pkg::ABM_DONE;
        end
      end
      abm_pkg::ABM_DONE: begin
        if (!reply_s) begin
          state_nxt = abm_pkg::ABM_REL;
        end
      end
      abm_pkg::ABM_REL: begin
        state_nxt = abm_pkg::ABM_IDLE;
      end
      abm_pkg::ABM_IAK: begin
        if (cnt_zero) begin
          state_nxt = abm_pkg::ABM_IAKW;
        end
      end
      abm_pkg::ABM_IAKW: begin
        if (reply_s || timed_out) begin
          state_nxt = abm_pkg::ABM_DONE;
        end
      end
      default: begin
        state_nxt = abm_pkg::ABM_IDLE;
      end
    endcase
  end

  wire state_chg = (state_nxt != state_r);
  wire waiting = (state_r == abm_pkg::ABM_WAIT) || (state_r == abm_pkg::ABM_IAKW);
  wire setup_st = (state_r == abm_pkg::ABM_ADDR) || (state_r == abm_pkg::ABM_SYNC)
               || (state_r == abm_pkg::ABM_STRB) || (state_r == abm_pkg::ABM_IAK);
  wire [abm_pkg::CNT_W-1:0] setup_ld = abm_pkg::CNT_W'(abm_pkg::SETUP_CYC - 1);
  wire finish = waiting && state_chg;
  wire strobe_nxt = (state_nxt == abm_pkg::ABM_STRB) || (state_nxt == abm_pkg::ABM_WAIT);

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_r <= abm_pkg::ABM_IDLE;
      cnt_r <= '0;
    end else if (ce_in) begin
      state_r <= state_nxt;
      if (state_chg) begin
        cnt_r <= (waiting || state_nxt == abm_pkg::ABM_IAKW
                  || state_nxt == abm_pkg::ABM_WAIT) ? '0 : setup_ld;
      end else if (waiting) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (setup_st && !cnt_zero) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      op_r <= abm_pkg::OP_READ;
      addr_r <= '0;
      wdata_r <= '0;
    end else if (ce_in && take_req) begin
      op_r <= req_op_in;
      addr_r <= req_addr_in;
      wdata_r <= req_wdata_in;
    end
  end

  // bus drive outputs, all released during reset
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      addr_data_lines_out <= '0;
      addr_data_lines_oe_out <= 1'b0;
      addr_phase_strobe_out <= 1'b0;
      read_data_strobe_out <= 1'b0;
      write_data_strobe_out <= 1'b0;
      write_byte_out <= 1'b0;
      io_page_select_out <= 1'b0;
      int_ack_out <= 1'b0;
    end else if (ce_in) begin
      // address strobe spans sync through done
      addr_phase_strobe_out <= (state_nxt == abm_pkg::ABM_SYNC) || (strobe_nxt)
                            || (state_nxt == abm_pkg::ABM_DONE && op_r != abm_pkg::OP_IACK);
      if (state_nxt == abm_pkg::ABM_ADDR || state_nxt == abm_pkg::ABM_SYNC) begin
        // held fields still belong to the previous request on the take edge
        addr_data_lines_out <= take_req ? drive_addr(req_addr_in) : addr_drv;
        addr_data_lines_oe_out <= 1'b1;
        io_page_select_out <= take_req ? in_io_page(req_addr_in) : is_io;
        write_byte_out <= take_req ? (req_op_in == abm_pkg::OP_WRITE) : is_write;
      end else if (strobe_nxt && is_write) begin
        addr_data_lines_out <= {6'h00, wdata_r};
        addr_data_lines_oe_out <= 1'b1;
        io_page_select_out <= 1'b0;
        write_byte_out <= 1'b0;
      end else begin
        addr_data_lines_out <= '0;
        addr_data_lines_oe_out <= 1'b0;
        io_page_select_out <= 1'b0;
        write_byte_out <= 1'b0;
      end
      read_data_strobe_out <= (strobe_nxt && op_r == abm_pkg::OP_READ)
                           || state_nxt == abm_pkg::ABM_IAK
                           || state_nxt == abm_pkg::ABM_IAKW;
      write_data_strobe_out <= strobe_nxt && is_write;
      int_ack_out <= (state_nxt == abm_pkg::ABM_IAKW);
    end
  end

  // user side answer
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      req_ready_out <= 1'b0;
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= '0;
      rsp_timeout_out <= 1'b0;
      rsp_mem_err_out <= 1'b0;
      irq_pending_out <= 1'b0;
    end else if (ce_in) begin
      req_ready_out <= (state_nxt == abm_pkg::ABM_IDLE);
      rsp_valid_out <= finish;
      irq_pending_out <= irq_any;
      if (finish) begin
        rsp_timeout_out <= !reply_s;
        // vector returned raw; user fetches the two words
        rsp_rdata_out <= is_write ? 16'h0000 : dal_s[15:0];
        rsp_mem_err_out <= reply_s && !is_write && (op_r != abm_pkg::OP_IACK) && dal_s[17]
                        && dal_s[16];
      end
    end
  end

  // no write strobe without an address strobe around it
  strobe_in_sync_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    write_data_strobe_out |-> addr_phase_strobe_out)
    else $error("write strobe outside address phase");
  // write strobe drops on the edge after the synchronised reply is seen in wait
  reply_ends_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && state_r == abm_pkg::ABM_WAIT && reply_s) |=> !write_data_strobe_out)
    else $error("write strobe held past reply");
  no_both_dir_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !(read_data_strobe_out && write_data_strobe_out))
    else $error("read and write strobes together");
  io_sel_addr_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    io_page_select_out |-> addr_data_lines_oe_out && addr_data_lines_out[21:13] == 9'h1FF)
    else $error("io page select without io address");
  reset_release_a: assert property (@(posedge clk_in)
    $past(sys_rst_in) && !sys_rst_in |-> !addr_data_lines_oe_out && !int_ack_out)
    else $error("bus driven after reset");
  rsp_one_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    rsp_valid_out |=> !rsp_valid_out)
    else $error("response longer than one cycle");
  iack_no_sync_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    int_ack_out |-> !addr_phase_strobe_out && read_data_strobe_out)
    else $error("interrupt acknowledge malformed");
  ready_idle_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    req_ready_out |-> !addr_phase_strobe_out && !read_data_strobe_out)
    else $error("ready while bus busy");

  // answer follows the synchronised reply by exactly one edge
  reply_done_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && state_r == abm_pkg::ABM_WAIT && reply_s) |=> rsp_valid_out && !rsp_timeout_out)
    else $error("reply not answered");
  iack_done_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && state_r == abm_pkg::ABM_IAKW && reply_s) |=> rsp_valid_out && !int_ack_out
      && !read_data_strobe_out)
    else $error("acknowledge not closed after vector");
  timeout_flag_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (ce_in && waiting && timed_out && !reply_s) |=> rsp_valid_out && rsp_timeout_out)
    else $error("missing reply not reported");
  strobe_end_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $fell(addr_phase_strobe_out) |-> !write_data_strobe_out && !read_data_strobe_out)
    else $error("data strobe outlives address strobe");
  ready_released_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    req_ready_out |-> !addr_data_lines_oe_out && !write_data_strobe_out && !int_ack_out)
    else $error("bus held while idle");
  write_data_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    write_data_strobe_out |-> addr_data_lines_oe_out && addr_data_lines_out[15:0] == wdata_r)
    else $error("write strobe without its data");
  read_release_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    read_data_strobe_out |-> !addr_data_lines_oe_out)
    else $error("lines driven during read");
endmodule : abm_master
`default_nettype wire

/* File: bench/abm_slave_model.sv */
// behavioural peripheral: register window at the I/O page bottom plus a little memory
`timescale 1ns/100ps
`default_nettype none
module abm_slave_model #(
  parameter logic [15:0] VEC = 16'h0088
) (
  input wire logic clk_in,
  input wire logic [21:0] dal_in,
  input wire logic sync_in,
  input wire logic rd_in,
  input wire logic wr_in,
  input wire logic iop_in,
  input wire logic iak_in,
  input wire logic [4:0] delay_in,
  input wire logic merr_in,
  output logic [21:0] dal_out,
  output logic dal_oe_out,
  output logic reply_out,
  output logic last_io_out,
  output logic [21:0] last_addr_out
);
  logic [15:0] regs [4];
  logic [15:0] mem [4];
  logic [4:0] cnt_r;
  logic [1:0] idx;
  logic hit;
  assign idx = last_addr_out[2:1];
  // own decode, qualified by page select only, offset from the low lines
  // a read strobe without the address strobe is an acknowledge, answered only when granted
  assign hit = sync_in ? (!last_io_out | (last_addr_out[12:3] == 10'h000)) : iak_in;
  initial begin
    {reply_out, dal_oe_out, last_io_out, cnt_r, dal_out, last_addr_out} = '0;
  end
  always @(posedge sync_in) begin
    last_addr_out <= dal_in;
    last_io_out <= iop_in;
  end
  always @(posedge clk_in) begin
    if (!(rd_in | wr_in)) begin
      {reply_out, dal_oe_out, cnt_r} <= '0;
    end else if (hit && !reply_out) begin
      if (cnt_r < delay_in) begin
        cnt_r <= cnt_r + 5'h01;
      end else begin
        reply_out <= 1'b1;
        if (wr_in && last_io_out) regs[idx] <= dal_in[15:0];
        else if (wr_in) mem[idx] <= dal_in[15:0];
        else begin
          dal_oe_out <= 1'b1;
          dal_out <= {4'h0, merr_in, merr_in, iak_in ? VEC : (last_io_out ? regs[idx] : mem[idx])};
        end
      end
    end
  end
endmodule : abm_slave_model
`default_nettype wire

/* File: bench/testbench.sv */
// self-checking bench: bus master controller against a peripheral model
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk_in = 0, sys_rst_in = 1, req_valid_in = 0, merr = 0, lvl5 = 0, lvl6 = 0;
  logic [1:0] req_op_in = 2'h0;
  logic [21:0] req_addr_in = 22'h000000, dal, dal_last = 22'h000000, d_out, m_out, last_addr;
  logic [15:0] req_wdata_in = 16'h0000, rsp_rdata_out, rd;
  logic req_ready_out, rsp_valid_out, rsp_timeout_out, rsp_mem_err_out, to, me;
  logic d_oe, m_oe, as, rs, ws, wb, iop, iak, reply, irq_pending_out, last_io;
  logic [4:0] delay = 5'h02;
  int miscompares = 0, cmp_count = 0;
  // released lines show a changing pattern, alternating each cycle between the last driven word and its inverse
  assign dal = d_oe ? d_out : (m_oe ? m_out : ~dal_last);
  always @(posedge clk_in) dal_last <= dal;
  // direction flag as the slave sees it when the address strobe rises
  logic wb_sync = 1'b0;
  always @(posedge as) wb_sync <= wb;
  always #25 clk_in = ~clk_in;
  abm_master #(.TIMEOUT(20)) dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(1'b1),
    .req_valid_in(req_valid_in), .req_op_in(req_op_in), .req_addr_in(req_addr_in),
    .req_wdata_in(req_wdata_in), .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
    .rsp_rdata_out(rsp_rdata_out), .rsp_timeout_out(rsp_timeout_out),
    .rsp_mem_err_out(rsp_mem_err_out), .addr_data_lines_in(dal), .addr_data_lines_out(d_out),
    .addr_data_lines_oe_out(d_oe), .addr_phase_strobe_out(as), .read_data_strobe_out(rs),
    .write_data_strobe_out(ws), .write_byte_out(wb), .io_page_select_out(iop),
    .int_ack_out(iak), .slave_reply_in(reply), .irq_level_five_in(lvl5),
    .irq_level_six_in(lvl6), .irq_pending_out(irq_pending_out));
  abm_slave_model #(.VEC(16'h0088)) model (.clk_in(clk_in), .dal_in(dal), .sync_in(as),
    .rd_in(rs), .wr_in(ws), .iop_in(iop), .iak_in(iak), .delay_in(delay), .merr_in(merr),
    .dal_out(m_out), .dal_oe_out(m_oe), .reply_out(reply), .last_io_out(last_io),
    .last_addr_out(last_addr));
  task automatic chk(input logic [21:0] seen, input logic [21:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic run_op(input logic [1:0] op, input logic [21:0] a, input logic [15:0] wd);
    int n;
    n = 0;
    while (req_ready_out !== 1'b1 && n < 400) begin
      @(posedge clk_in) #1 n++;
    end
    {req_op_in, req_addr_in, req_wdata_in, req_valid_in} = {op, a, wd, 1'b1};
    @(posedge clk_in) #1 req_valid_in = 0;
    n = 0;
    while (rsp_valid_out !== 1'b1 && n < 400) begin
      @(posedge clk_in) #1 n++;
    end
    if (n >= 400) miscompares++;
    {rd, to, me} = {rsp_rdata_out, rsp_timeout_out, rsp_mem_err_out};
  endtask : run_op
  task automatic t_reset();
    repeat (6) @(posedge clk_in);
    #1 chk({req_ready_out, d_oe, as, rs, ws, iak}, 22'h0);
    sys_rst_in = 0;
    @(posedge clk_in) #1 chk(req_ready_out, 22'h1);
  endtask : t_reset
  task automatic t_io_mem();
    run_op(2'h1, 22'h3FE000, 16'hA5C3);
    chk({last_io, last_addr[12:0]}, 22'h002000);
    chk(wb_sync, 22'h1);
    run_op(2'h1, 22'h3FE006, 16'h5A3C);
    chk(to, 22'h0);
    run_op(2'h1, 22'h3FDFFE, 16'h1234);
    chk(last_io, 22'h0);
    run_op(2'h0, 22'h3FE000, 16'h0000);
    chk({to, me, rd}, 22'h00A5C3);
    chk(wb_sync, 22'h0);
    run_op(2'h0, 22'h3FE006, 16'h0000);
    chk({to, rd}, 22'h005A3C);
    run_op(2'h0, 22'h3FDFFE, 16'h0000);
    chk({to, rd}, 22'h001234);
  endtask : t_io_mem
  task automatic t_decode();
    // unclaimed page offset: nobody replies, controller must give up
    run_op(2'h0, 22'h3FE010, 16'h0000);
    chk(to, 22'h1);
    run_op(2'h0, 22'h3FE000, 16'h0000);
    chk({to, rd}, 22'h00A5C3);
  endtask : t_decode
  task automatic t_slow();
    delay = 5'h0C;
    run_op(2'h0, 22'h3FE006, 16'h0000);
    chk({to, rd}, 22'h005A3C);
    delay = 5'h02;
  endtask : t_slow
  task automatic t_merr();
    merr = 1;
    run_op(2'h0, 22'h3FDFFE, 16'h0000);
    chk({me, rd}, 22'h011234);
    merr = 0;
  endtask : t_merr
  task automatic t_irq();
    delay = 5'h04;
    for (int i = 0; i < 2; i++) begin
      {lvl6, lvl5} = (i == 0) ? 2'h1 : 2'h2;
      repeat (4) @(posedge clk_in);
      #1 chk(irq_pending_out, 22'h1);
      run_op(2'h2, 22'h000000, 16'h0000);
      chk({to, rd}, 22'h000088);
      {lvl6, lvl5} = 2'h0;
      repeat (4) @(posedge clk_in);
      #1 chk(irq_pending_out, 22'h0);
    end
  endtask : t_irq
  task automatic report_and_stop();
    $display("comparisons %0d, miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    t_reset();
    t_io_mem();
    t_decode();
    t_slow();
    t_merr();
    t_irq();
    report_and_stop();
  end
  // whole run needs well under a thousand cycles
  initial begin
    #(50 * 20000);
    miscompares++;
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
